// *** design/mct_pkg.sv ***
// Purpose: shared constants and types of the instruction timing sequencer
// Assumes: one 50 MHz clock, synchronous active-high reset
// Notes:   decode record carries bytes, base cycles and branch flag
package mct_pkg;

	// ****************************************
	// clock and timing
	// ****************************************
	localparam int unsigned   CLK_PERIOD_NS = 20;
	localparam int unsigned   CORE_FMAX_HZ  = 25_000_000;
	localparam logic [3:0]    MAX_CYCLES    = 4'h8;

	// ****************************************
	// encodings and reset values
	// ****************************************
	localparam logic [7:0]    OP_RESERVED   = 8'ha5;
	localparam logic [7:0]    OP_RST        = 8'h00;
	localparam logic [3:0]    CNT_RST       = 4'h0;
	localparam logic [3:0]    CNT_FIRST     = 4'h1;

	// ****************************************
	// types
	// ****************************************
	typedef struct packed
	{
		logic [1:0] len;
		logic [3:0] cyc;
		logic       cond;
		logic       illegal;
	} mct_dec_t;

	localparam mct_dec_t      DEC_RST = '{len: 2'h1, cyc: 4'h1,
		cond: 1'b0, illegal: 1'b0};

	typedef enum logic [1:0]
	{
		ST_IDLE,
		ST_EXEC,
		ST_EXTEND
	} mct_state_t;

endpackage

// *** design/mct_dec_if.sv ***
// Purpose: carries an opcode to the decoder and its timing record back
// Assumes: purely combinational path on one clock
// Notes:   dec modport is the decoder side, seq the sequencer side
`timescale 1ns/1ps
`default_nettype none

interface mct_dec_if;
	import mct_pkg::*;

	logic [7:0] opcode;
	mct_dec_t   info;

	modport dec
	(
		input  opcode,
		output info
	);

	modport seq
	(
		output opcode,
		input  info
	);

endinterface

`default_nettype wire

// *** design/mct_decode.sv ***
// Purpose: maps every opcode to byte length, base cycles, branch flag
// Assumes: legacy accumulator instruction set encoding
// Notes:   conditional branches add one cycle when taken
`timescale 1ns/1ps
`default_nettype none

module mct_decode
	import mct_pkg::*;
(
	// opcode in, timing record out
	mct_dec_if.dec dif
);

	function automatic mct_dec_t mk(input logic [1:0] l,
		input logic [3:0] c, input logic k);
		mct_dec_t r;
		r = '{len: l, cyc: c, cond: k, illegal: 1'b0};
		return r;
	endfunction

	// ****************************************
	// opcode table
	// ****************************************
	// one record per opcode; only the reserved code is refused
	function automatic mct_dec_t decode(input logic [7:0] op);
		logic [3:0] hi;
		mct_dec_t   r;
		hi = op[7:4];
		r  = DEC_RST;
		if (op[3])
		begin
			case (hi)
				4'h7, 4'h8, 4'ha: r = mk(2'h2, 4'h2, 1'b0);
				4'hb:             r = mk(2'h3, 4'h3, 1'b1);
				4'hd:             r = mk(2'h2, 4'h2, 1'b1);
				default:          r = mk(2'h1, 4'h1, 1'b0);
			endcase
		end
		else
		begin
			case (op[3:0])
				4'h0: case (hi)
					4'h0:                   r = mk(2'h1, 4'h1, 1'b0);
					4'h1, 4'h2, 4'h3:       r = mk(2'h3, 4'h3, 1'b1);
					4'h4, 4'h5, 4'h6, 4'h7: r = mk(2'h2, 4'h2, 1'b1);
					4'h8:                   r = mk(2'h2, 4'h3, 1'b0);
					4'h9:                   r = mk(2'h3, 4'h3, 1'b0);
					4'he, 4'hf:             r = mk(2'h1, 4'h3, 1'b0);
					default:                r = mk(2'h2, 4'h2, 1'b0);
				endcase
				4'h1: r = mk(2'h2, 4'h3, 1'b0);
				4'h2: case (hi)
					4'h0, 4'h1: r = mk(2'h3, 4'h4, 1'b0);
					4'h2, 4'h3: r = mk(2'h1, 4'h5, 1'b0);
					4'he, 4'hf: r = mk(2'h1, 4'h3, 1'b0);
					default:    r = mk(2'h2, 4'h2, 1'b0);
				endcase
				4'h3: case (hi)
					4'h4, 4'h5, 4'h6:             r = mk(2'h3, 4'h3, 1'b0);
					4'h7, 4'h8, 4'h9, 4'he, 4'hf: r = mk(2'h1, 4'h3, 1'b0);
					default:                      r = mk(2'h1, 4'h1, 1'b0);
				endcase
				4'h4: case (hi)
					4'h0, 4'h1, 4'hc, 4'hd, 4'he, 4'hf:
						r = mk(2'h1, 4'h1, 1'b0);
					4'h8:    r = mk(2'h1, MAX_CYCLES, 1'b0);
					4'ha:    r = mk(2'h1, 4'h4, 1'b0);
					4'hb:    r = mk(2'h3, 4'h3, 1'b1);
					default: r = mk(2'h2, 4'h2, 1'b0);
				endcase
				4'h5: case (hi)
					4'h7, 4'h8: r = mk(2'h3, 4'h3, 1'b0);
					4'ha:
					begin
						r         = mk(2'h1, 4'h1, 1'b0);
						r.illegal = 1'b1;
					end
					4'hb:       r = mk(2'h3, 4'h4, 1'b1);
					4'hd:       r = mk(2'h3, 4'h3, 1'b1);
					default:    r = mk(2'h2, 4'h2, 1'b0);
				endcase
				default: case (hi)
					4'h7, 4'h8, 4'ha: r = mk(2'h2, 4'h2, 1'b0);
					4'hb:             r = mk(2'h3, 4'h4, 1'b1);
					default:          r = mk(2'h1, 4'h2, 1'b0);
				endcase
			endcase
		end
		return r;
	endfunction

	always_comb
	begin
		dif.info = decode(dif.opcode);
	end

endmodule

`default_nettype wire

// *** design/mct_core_timing.sv ***
// Purpose: instruction timing sequencer of the 8-bit core
// Assumes: program memory offers one byte per cycle with a valid flag
// Notes:   outputs are registered; done reports one cycle after the end
`timescale 1ns/1ps
`default_nettype none

module mct_core_timing
	import mct_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// program memory byte stream
	input  wire logic [7:0] code_byte,
	input  wire logic       code_valid,
	// condition result from the datapath
	input  wire logic       branch_cond,
	// fetch control
	output logic            code_want,
	output logic            fetch_flush,
	// instruction progress
	output logic            instr_start,
	output logic [7:0]      instr_opcode,
	output logic [3:0]      exec_cycle,
	output logic            busy,
	output logic [7:0]      operand_byte,
	output logic            operand_strobe,
	// completion report
	output logic            instr_done,
	output logic [3:0]      instr_cycles,
	output logic [1:0]      instr_bytes,
	output logic            branch_taken,
	output logic            illegal_opcode
);

	// ****************************************
	// state and decoder
	// ****************************************
	mct_state_t state_reg;
	mct_state_t state_next;
	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;
	logic [7:0] op_reg;
	logic [7:0] op_next;
	mct_dec_t   info_reg;
	mct_dec_t   info_next;
	logic       want_reg;
	logic       want_next;
	logic       in_exec;
	logic       need_byte;
	logic       stall;
	logic       at_end;
	logic       taken_now;
	logic       finish;
	logic       accept;

	logic       start_reg;
	logic       done_reg;
	logic [3:0] cycles_reg;
	logic [1:0] bytes_reg;
	logic       taken_reg;
	logic       flush_reg;
	logic       illegal_reg;
	logic       busy_reg;
	logic [7:0] operand_reg;
	logic       strobe_reg;

	mct_dec_if dif ();

	assign dif.opcode = code_byte;

	// every opcode is timed from this one table
	mct_decode u_decode
	(
		.dif (dif)
	);

	// ****************************************
	// cycle sequencing
	// ****************************************
	// operand bytes are fetched in cycles 1 to len-1; the last
	// cycle already takes the next opcode, so cycles must be at least len
	always_comb
	begin
		in_exec   = (state_reg == ST_EXEC);
		need_byte = in_exec && (cnt_reg < {2'h0, info_reg.len});
		stall     = need_byte && !code_valid;
		at_end    = in_exec && (cnt_reg == info_reg.cyc);
		taken_now = at_end && info_reg.cond && branch_cond;
		finish    = (at_end && !taken_now) || (state_reg == ST_EXTEND);
		accept    = want_reg && code_valid
			&& ((state_reg == ST_IDLE) || finish);
	end

	always_comb
	begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		op_next    = op_reg;
		info_next  = info_reg;
		if (accept)
		begin
			state_next = ST_EXEC;
			cnt_next   = CNT_FIRST;
			op_next    = code_byte;
			info_next  = dif.info;
		end
		else if (finish)
		begin
			state_next = ST_IDLE;
			cnt_next   = CNT_RST;
		end
		else if (taken_now)
		begin
			// fall-through byte already offered is thrown away
			state_next = ST_EXTEND;
			cnt_next   = 4'(cnt_reg + 4'h1);
		end
		else if (in_exec && !stall)
		begin
			cnt_next = 4'(cnt_reg + 4'h1);
		end
		want_next = (state_next != ST_EXEC)
			|| (cnt_next < {2'h0, info_next.len})
			|| (cnt_next == info_next.cyc);
	end

	// no minimum clock rate: fully static, edge-counted logic
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_reg <= ST_IDLE;
			cnt_reg   <= CNT_RST;
			op_reg    <= OP_RST;
			info_reg  <= DEC_RST;
			want_reg  <= 1'b1;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			op_reg    <= op_next;
			info_reg  <= info_next;
			want_reg  <= want_next;
		end
	end

	// ****************************************
	// progress and completion reports
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			start_reg   <= 1'b0;
			illegal_reg <= 1'b0;
			busy_reg    <= 1'b0;
			strobe_reg  <= 1'b0;
			operand_reg <= OP_RST;
			flush_reg   <= 1'b0;
		end
		else
		begin
			start_reg   <= accept;
			illegal_reg <= accept && dif.info.illegal;
			busy_reg    <= (state_next != ST_IDLE);
			strobe_reg  <= need_byte && code_valid;
			flush_reg   <= taken_now && code_valid;
			if (need_byte && code_valid)
			begin
				operand_reg <= code_byte;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			done_reg   <= 1'b0;
			cycles_reg <= CNT_RST;
			bytes_reg  <= 2'h0;
			taken_reg  <= 1'b0;
		end
		else
		begin
			done_reg  <= finish;
			taken_reg <= finish && (state_reg == ST_EXTEND);
			if (finish)
			begin
				cycles_reg <= cnt_reg;
				bytes_reg  <= info_reg.len;
			end
		end
	end

	assign code_want      = want_reg;
	assign fetch_flush    = flush_reg;
	assign instr_start    = start_reg;
	assign instr_opcode   = op_reg;
	assign exec_cycle     = cnt_reg;
	assign busy           = busy_reg;
	assign operand_byte   = operand_reg;
	assign operand_strobe = strobe_reg;
	assign instr_done     = done_reg;
	assign instr_cycles   = cycles_reg;
	assign instr_bytes    = bytes_reg;
	assign branch_taken   = taken_reg;
	assign illegal_opcode = illegal_reg;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_take(logic [7:0] m, logic [7:0] v);
		accept && ((code_byte & m) == v);
	endsequence

	sequence s_done(logic [3:0] n);
		instr_done && (instr_cycles == n);
	endsequence

	property p_max_cycles;
		(state_reg != ST_IDLE) |-> (cnt_reg <= MAX_CYCLES);
	endproperty
	a_max_cycles: assert property (p_max_cycles)
		else $error("execution count above eight");

	property p_clock_count;
		(in_exec && !stall && !finish) |=> (cnt_reg == 4'($past(cnt_reg) + 4'h1));
	endproperty
	a_clock_count: assert property (p_clock_count)
		else $error("cycle count did not advance by one");

	property p_not_taken;
		(finish && in_exec && info_reg.cond)
			|=> (instr_cycles == $past(info_reg.cyc)) && !branch_taken;
	endproperty
	a_not_taken: assert property (p_not_taken)
		else $error("untaken branch length wrong");

	property p_taken;
		(state_reg == ST_EXTEND)
			|=> (instr_cycles == 4'($past(info_reg.cyc) + 4'h1)) && branch_taken;
	endproperty
	a_taken: assert property (p_taken)
		else $error("taken branch length wrong");

	property p_len_eq_cyc;
		(accept && (code_byte[3:0] == 4'h5) && !dif.info.cond
			&& !dif.info.illegal)
			|-> (dif.info.cyc == {2'h0, dif.info.len});
	endproperty
	a_len_eq_cyc: assert property (p_len_eq_cyc)
		else $error("direct form cycles differ from bytes");

	property p_reserved;
		s_take(8'hff, OP_RESERVED) |=> illegal_opcode;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved opcode not flagged");

	property p_carry_reg;
		(s_take(8'hf8, 8'h38) or s_take(8'hf8, 8'h98)) |=> ##1 s_done(4'h1);
	endproperty
	a_carry_reg: assert property (p_carry_reg)
		else $error("carry or borrow register form not 1 cycle");

	property p_arith_direct;
		(s_take(8'hef, 8'h25) or s_take(8'hff, 8'h95))
			|-> (dif.info.len == 2'h2) && (dif.info.cyc == 4'h2);
	endproperty
	a_arith_direct: assert property (p_arith_direct)
		else $error("direct arithmetic not 2 bytes 2 cycles");

	property p_arith_indirect;
		(s_take(8'hee, 8'h26) or s_take(8'hfe, 8'h96)) |=> ##2 s_done(4'h2);
	endproperty
	a_arith_indirect: assert property (p_arith_indirect)
		else $error("indirect arithmetic not 2 cycles");

	property p_arith_imm;
		(s_take(8'hef, 8'h24) or s_take(8'hff, 8'h94))
			|-> (dif.info.len == 2'h2) && (dif.info.cyc == 4'h2);
	endproperty
	a_arith_imm: assert property (p_arith_imm)
		else $error("immediate arithmetic not 2 bytes 2 cycles");

	property p_incdec_fast;
		(s_take(8'he8, 8'h08) or s_take(8'hef, 8'h04)) |=> ##1 s_done(4'h1);
	endproperty
	a_incdec_fast: assert property (p_incdec_fast)
		else $error("register increment not 1 cycle");

	property p_incdec_mem;
		s_take(8'hee, 8'h06) |=> ##2 s_done(4'h2);
	endproperty
	a_incdec_mem: assert property (p_incdec_mem)
		else $error("indirect increment not 2 cycles");

	property p_data_pointer_inc;
		s_take(8'hff, 8'ha3) |=> ##1 s_done(4'h1);
	endproperty
	a_data_pointer_inc: assert property (p_data_pointer_inc)
		else $error("pointer increment not 1 cycle");

	property p_logic_reg;
		(s_take(8'hf8, 8'h48) or s_take(8'hf8, 8'h58) or s_take(8'hf8, 8'h68))
			|=> ##1 s_done(4'h1);
	endproperty
	a_logic_reg: assert property (p_logic_reg)
		else $error("logical register form not 1 cycle");

	property p_logic_dir_acc;
		(s_take(8'hef, 8'h42) or s_take(8'hff, 8'h62))
			|-> (dif.info.len == 2'h2) && (dif.info.cyc == 4'h2);
	endproperty
	a_logic_dir_acc: assert property (p_logic_dir_acc)
		else $error("logical direct,acc not 2 bytes 2 cycles");

	property p_logic_dir_imm;
		(s_take(8'hef, 8'h43) or s_take(8'hff, 8'h63))
			|-> (dif.info.len == 2'h3) && (dif.info.cyc == 4'h3);
	endproperty
	a_logic_dir_imm: assert property (p_logic_dir_imm)
		else $error("logical direct,imm not 3 bytes 3 cycles");

	property p_add_reg;
		s_take(8'hf8, 8'h28) |=> ##1 s_done(4'h1);
	endproperty
	a_add_reg: assert property (p_add_reg)
		else $error("add register not 1 cycle");

	property p_multiply;
		s_take(8'hff, 8'ha4) |=> ##4 s_done(4'h4);
	endproperty
	a_multiply: assert property (p_multiply)
		else $error("multiply not 4 cycles");

	property p_divide;
		s_take(8'hff, 8'h84) |=> ##8 s_done(MAX_CYCLES);
	endproperty
	a_divide: assert property (p_divide)
		else $error("divide not 8 cycles");

	property p_decimal_adj;
		s_take(8'hff, 8'hd4) |=> ##1 s_done(4'h1);
	endproperty
	a_decimal_adj: assert property (p_decimal_adj)
		else $error("decimal adjust not 1 cycle");

endmodule

`default_nettype wire

// *** testbench/mct_prog_mem.sv ***
// Purpose: program memory model feeding the code byte stream
// Assumes: bytes change 1 ns after the rising edge
// Notes:   idle bus shows the inverse of the last byte, never a stale copy
`timescale 1ns/1ps
`default_nettype none

module mct_prog_mem
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// byte stream
	input  wire logic       code_want,
	output var  logic [7:0] code_byte,
	output var  logic       code_valid
);
	logic [7:0] q[$];
	logic [7:0] last_reg = 8'h00;
	int         gap      = 0;
	int         gap_left = 0;

	initial
	begin
		code_byte = 8'h00;
		code_valid = 1'b0;
	end

	task automatic push(input logic [7:0] b);
		q.push_back(b);
	endtask

	task automatic clear();
		q.delete();
	endtask

	// slow memory: idle cycles after every byte taken
	task automatic set_gap(input int g);
		gap = g;
	endtask

	always @(posedge clk)
	begin
		if (rst)
			gap_left = 0;
		else if (code_valid && code_want && q.size() != 0)
		begin
			void'(q.pop_front());
			gap_left = gap;
		end
		else if (gap_left > 0)
			gap_left--;
		#1;
		if (q.size() != 0 && gap_left == 0)
		begin
			code_byte = q[0];
			code_valid = 1'b1;
			last_reg = q[0];
		end
		else
		begin
			code_byte = ~last_reg;
			code_valid = 1'b0;
		end
	end

endmodule

`default_nettype wire

// *** testbench/mct_core_timing_test.sv ***
// Purpose: self-checking bench of the instruction timing sequencer
// Assumes: one instruction in flight per scenario unless stated
// Notes:   operand bytes are 0x11, 0x12 so operand_byte shows the last one
`timescale 1ns/1ps
`default_nettype none

module mct_core_timing_test
	import mct_pkg::*;
;
	logic       clk = 1'b0;
	logic       rst;
	logic       branch_cond;
	logic [7:0] code_byte;
	logic       code_valid;
	logic       code_want;
	logic       fetch_flush;
	logic       instr_start;
	logic [7:0] instr_opcode;
	logic [3:0] exec_cycle;
	logic       busy;
	logic [7:0] operand_byte;
	logic       operand_strobe;
	logic       instr_done;
	logic [3:0] instr_cycles;
	logic [1:0] instr_bytes;
	logic       branch_taken;
	logic       illegal_opcode;
	logic       flush_seen = 1'b0;
	logic       over = 1'b0;
	int         error_cnt = 0;
	int         tests_run = 0;
	int         strobe_cnt = 0;

	always #10 clk = ~clk;

	mct_core_timing u_mct_core_timing
	(
		.clk            (clk),
		.rst            (rst),
		.code_byte      (code_byte),
		.code_valid     (code_valid),
		.branch_cond    (branch_cond),
		.code_want      (code_want),
		.fetch_flush    (fetch_flush),
		.instr_start    (instr_start),
		.instr_opcode   (instr_opcode),
		.exec_cycle     (exec_cycle),
		.busy           (busy),
		.operand_byte   (operand_byte),
		.operand_strobe (operand_strobe),
		.instr_done     (instr_done),
		.instr_cycles   (instr_cycles),
		.instr_bytes    (instr_bytes),
		.branch_taken   (branch_taken),
		.illegal_opcode (illegal_opcode)
	);

	mct_prog_mem u_mct_prog_mem
	(
		.clk        (clk),
		.rst        (rst),
		.code_want  (code_want),
		.code_byte  (code_byte),
		.code_valid (code_valid)
	);

	// ****************************************
	// monitors
	// ****************************************
	always @(posedge clk)
	begin
		if (fetch_flush === 1'b1)
			flush_seen <= 1'b1;
		if (exec_cycle > MAX_CYCLES)
			over <= 1'b1;
		if (operand_strobe === 1'b1)
			strobe_cnt <= strobe_cnt + 1;
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic tick();
		@(posedge clk);
		#1;
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] exp,
		input logic [7:0] got);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wait_ev(input logic want_done, output int n);
		n = 0;
		while ((want_done ? instr_done : instr_start) !== 1'b1 && n < 40)
		begin
			tick();
			n++;
		end
		if (n == 40)
		begin
			error_cnt++;
			$display("[FAIL] handshake expected pulse seen timeout");
			print_verdict();
		end
	endtask

	// a dropped fall-through byte may still run; idle it out
	task automatic settle();
		u_mct_prog_mem.clear();
		branch_cond = 1'b0;
		repeat (12) tick();
	endtask

	task automatic run_op(input logic [7:0] op, input logic [1:0] len,
		input logic [3:0] cyc, input logic tk, input int g);
		int n;
		u_mct_prog_mem.set_gap(g);
		branch_cond = tk;
		u_mct_prog_mem.push(op);
		for (n = 1; n < len; n++)
			u_mct_prog_mem.push(8'h10 + 8'(n));
		if (tk)
			u_mct_prog_mem.push(8'h00);
		wait_ev(1'b0, n);
		chk("illegal_opcode", {7'h0, op == OP_RESERVED}, {7'h0, illegal_opcode});
		chk("busy", 8'h01, {7'h0, busy});
		chk("exec_cycle", 8'h01, {4'h0, exec_cycle});
		flush_seen = 1'b0;
		over = 1'b0;
		strobe_cnt = 0;
		wait_ev(1'b1, n);
		chk("done delay", 8'(int'(cyc) + int'(tk) + (int'(len) - 1) * g), 8'(n));
		chk("instr_cycles", 8'(cyc + tk), {4'h0, instr_cycles});
		chk("instr_bytes", {6'h0, len}, {6'h0, instr_bytes});
		chk("instr_opcode", op, instr_opcode);
		chk("branch_taken", {7'h0, tk}, {7'h0, branch_taken});
		chk("fetch_flush", {7'h0, tk}, {7'h0, flush_seen});
		chk("cycle ceiling", 8'h00, {7'h0, over});
		chk("operand strobes", 8'(len - 2'h1), 8'(strobe_cnt));
		chk("busy end", 8'h00, {7'h0, busy});
		if (len > 2'h1)
			chk("operand_byte", 8'h10 + 8'(len - 2'h1), operand_byte);
		settle();
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		chk("code_want", 8'h01, {7'h0, code_want});
		chk("busy", 8'h00, {7'h0, busy});
		chk("exec_cycle", 8'h00, {4'h0, exec_cycle});
		chk("instr_opcode", 8'h00, instr_opcode);
		chk("instr_cycles", 8'h00, {4'h0, instr_cycles});
		chk("instr_bytes", 8'h00, {6'h0, instr_bytes});
		$display("reset values done");
	endtask

	task automatic t_arith();
		run_op(8'h28, 2'h1, 4'h1, 1'b0, 0);
		run_op(8'h38, 2'h1, 4'h1, 1'b0, 0);
		run_op(8'h98, 2'h1, 4'h1, 1'b0, 0);
		run_op(8'h25, 2'h2, 4'h2, 1'b0, 0);
		run_op(8'h26, 2'h1, 4'h2, 1'b0, 0);
		run_op(8'h24, 2'h2, 4'h2, 1'b0, 0);
		run_op(8'h04, 2'h1, 4'h1, 1'b0, 0);
		run_op(8'h08, 2'h1, 4'h1, 1'b0, 0);
		run_op(8'h15, 2'h2, 4'h2, 1'b0, 0);
		run_op(8'h06, 2'h1, 4'h2, 1'b0, 0);
		run_op(8'ha3, 2'h1, 4'h1, 1'b0, 0);
		run_op(8'ha4, 2'h1, 4'h4, 1'b0, 0);
		run_op(8'h84, 2'h1, 4'h8, 1'b0, 0);
		run_op(8'hd4, 2'h1, 4'h1, 1'b0, 0);
		$display("arithmetic timing done");
	endtask

	task automatic t_logic();
		run_op(8'h58, 2'h1, 4'h1, 1'b0, 0);
		run_op(8'h45, 2'h2, 4'h2, 1'b0, 0);
		run_op(8'h66, 2'h1, 4'h2, 1'b0, 0);
		run_op(8'h54, 2'h2, 4'h2, 1'b0, 0);
		run_op(8'h52, 2'h2, 4'h2, 1'b0, 0);
		run_op(8'h62, 2'h2, 4'h2, 1'b0, 0);
		run_op(8'h53, 2'h3, 4'h3, 1'b0, 0);
		run_op(8'h43, 2'h3, 4'h3, 1'b0, 0);
		run_op(8'h63, 2'h3, 4'h3, 1'b0, 2);
		$display("logical timing done");
	endtask

	task automatic t_branch();
		run_op(8'h60, 2'h2, 4'h2, 1'b0, 0);
		run_op(8'h70, 2'h2, 4'h2, 1'b1, 0);
		run_op(OP_RESERVED, 2'h1, 4'h1, 1'b0, 0);
		$display("branch and reserved done");
	endtask

	task automatic t_b2b();
		int n;
		u_mct_prog_mem.set_gap(0);
		u_mct_prog_mem.push(8'h24);
		u_mct_prog_mem.push(8'h11);
		u_mct_prog_mem.push(8'h04);
		wait_ev(1'b0, n);
		wait_ev(1'b1, n);
		chk("first delay", 8'h02, 8'(n));
		chk("next start", 8'h01, {7'h0, instr_start});
		chk("operand_byte", 8'h11, operand_byte);
		tick();
		chk("second done", 8'h01, {7'h0, instr_done});
		chk("second opcode", 8'h04, instr_opcode);
		chk("second cycles", 8'h01, {4'h0, instr_cycles});
		settle();
		$display("back to back done");
	endtask

	task automatic t_abort();
		int n;
		u_mct_prog_mem.push(8'h84);
		wait_ev(1'b0, n);
		tick();
		rst = 1'b1;
		tick();
		rst = 1'b0;
		t_reset();
		settle();
		run_op(8'ha4, 2'h1, 4'h4, 1'b0, 0);
		$display("reset abort done");
	endtask

	initial
	begin
		rst = 1'b1;
		branch_cond = 1'b0;
		repeat (5) @(posedge clk);
		#1;
		rst = 1'b0;
		t_reset();
		tick();
		t_reset();
		t_arith();
		t_logic();
		t_branch();
		t_b2b();
		t_abort();
		print_verdict();
	end

endmodule

`default_nettype wire
